// File: shared/hub_params.svh
// constants for the hub port power control block
//
// What this block does
// - memory select high: report built-in default vendor and product ids
// - individual mode: each port power switch follows its own host request
// - individual mode: overcurrent removes power from the affected port only
// - ganged mode: all ports powered whenever any port needs power
// - ganged mode: shared power stays on until no port needs it
// - ganged mode: any overcurrent switches off all ports together
// - bus or self powered mode follows the power source select input
// - self powered runs seven ports, bus powered only four
// - pull-up disable held 15 ms after reset and after mode change
// - each port detects full or low speed and sets its signalling
`ifndef HUB_PARAMS_SVH
`define HUB_PARAMS_SVH

`define HUB_NUM_PORTS        7
`define HUB_BUS_PORTS_MASK   7'h0f
`define HUB_SELF_PORTS_MASK  7'h7f

// timing
`define HUB_CLK_MHZ          200
`define HUB_PULLUP_HOLD_MS   15
`define HUB_PULLUP_HOLD_CYC  (`HUB_PULLUP_HOLD_MS * `HUB_CLK_MHZ * 1000)

// register byte offsets
`define HUB_OFS_CTRL         8'h00
`define HUB_OFS_PWR_REQ      8'h04
`define HUB_OFS_STATUS       8'h08
`define HUB_OFS_IRQ_STAT     8'h0c
`define HUB_OFS_IRQ_MASK     8'h10
`define HUB_OFS_ID           8'h14
`define HUB_OFS_SPEED        8'h18

// field positions
`define HUB_CTRL_GANG_BIT    0
`define HUB_ST_POWER_SOURCE_SELECT_N_BIT    0
`define HUB_ST_PULLUP_BIT    1
`define HUB_ST_MEMSEL_BIT    2
`define HUB_ST_POWER_LSB     8
`define HUB_ST_OVC_LSB       16

// reset values
`define HUB_CTRL_RST         1'b0
`define HUB_PWR_REQ_RST      7'h00
`define HUB_IRQ_MASK_RST     7'h00

// built-in ids, values arbitrary
`define HUB_DEFAULT_VID      16'h1a2b
`define HUB_DEFAULT_PID      16'h3c4d

`endif

// File: shared/hub_pkg.sv
// types for the hub port power control block
`include "hub_params.svh"
package hub_pkg;

   typedef logic [`HUB_NUM_PORTS-1:0] port_vec_t;

   typedef enum logic [1:0] {
      RESP_OKAY   = 2'h0,
      RESP_SLVERR = 2'h2
   } resp_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [2:0] prot;
   } axi_addr_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  strb;
   } axi_wdata_t;

   typedef struct packed {
      logic [31:0] data;
      resp_t       resp;
   } axi_rdata_t;

endpackage

// File: src/pullup_timer.sv
// upstream pull-up disable pulse timer
`include "hub_params.svh"
module pullup_timer #(
   parameter int unsigned HOLD_CYCLES = `HUB_PULLUP_HOLD_CYC
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic ce_i,
   input  wire logic restart_i,
   output logic      active_o
);
   localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(HOLD_CYCLES - 1);

   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic          active_reg;
   logic          active_next;

   always_comb begin
      count_next  = count_reg;
      active_next = active_reg;
      if (restart_i) begin
         count_next  = LOAD;
         active_next = 1'b1;
      end else if (active_reg) begin
         if (count_reg == '0) begin
            active_next = 1'b0;
         end else begin
            count_next = count_reg - CW'(1);
         end
      end
   end

   // held active from reset onward
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_reg  <= LOAD;
         active_reg <= 1'b1;
      end else if (ce_i) begin
         count_reg  <= count_next;
         active_reg <= active_next;
      end
   end

   assign active_o = active_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   restart_hold_a: assert property (@(posedge clk_i)
      disable iff (!nrst_i) (ce_i && restart_i) |=> active_o [*2])
      else $error("pull-up disable not held after restart");

   release_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (ce_i && active_reg && count_reg == '0 && !restart_i) |=> !active_o)
      else $error("pull-up disable not released at end of count");

endmodule

// File: src/hub_port_power_control.sv
// hub downstream port power, mode, id and speed control with axi4-lite
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`include "hub_params.svh"
module hub_port_power_control #(
   parameter int unsigned PULLUP_HOLD_CYCLES = `HUB_PULLUP_HOLD_CYC
) (
   input  wire logic                CORE_CLK_I,
   input  wire logic                NRST_I,
   input  wire logic                CORE_CE_I,
   input  wire logic                S_AXI_AWVALID_I,
   output logic                     S_AXI_AWREADY_O,
   input  wire hub_pkg::axi_addr_t  S_AXI_AW_I,
   input  wire logic                S_AXI_WVALID_I,
   output logic                     S_AXI_WREADY_O,
   input  wire hub_pkg::axi_wdata_t S_AXI_W_I,
   output logic                     S_AXI_BVALID_O,
   input  wire logic                S_AXI_BREADY_I,
   output hub_pkg::resp_t           S_AXI_BRESP_O,
   input  wire logic                S_AXI_ARVALID_I,
   output logic                     S_AXI_ARREADY_O,
   input  wire hub_pkg::axi_addr_t  S_AXI_AR_I,
   output logic                     S_AXI_RVALID_O,
   input  wire logic                S_AXI_RREADY_I,
   output hub_pkg::axi_rdata_t      S_AXI_R_O,
   output logic                     IRQ_O,
   input  wire logic                SERIAL_MEMORY_SELECT_N_I,
   input  wire logic [31:0]         SERIAL_MEMORY_ID_I,
   input  wire logic                POWER_SOURCE_SELECT_N_I,
   input  wire hub_pkg::port_vec_t  PORT_OVERCURRENT_SENSE_N_I,
   output hub_pkg::port_vec_t       PORT_POWER_SWITCH_ENABLE_O,
   output logic                     UPSTREAM_PULLUP_DISABLE_O,
   input  wire hub_pkg::port_vec_t  PORT_DATA_PLUS_I,
   input  wire hub_pkg::port_vec_t  PORT_DATA_MINUS_I,
   output hub_pkg::port_vec_t       PORT_LOW_SPEED_O,
   output logic [31:0]              REPORTED_ID_O
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic hub_pkg::port_vec_t merge_low(
      input hub_pkg::port_vec_t old_v,
      input hub_pkg::axi_wdata_t w
   );
      merge_low = w.strb[0] ? w.data[`HUB_NUM_PORTS-1:0] : old_v;
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      case ({addr[7:2], 2'h0})
         `HUB_OFS_CTRL, `HUB_OFS_PWR_REQ, `HUB_OFS_STATUS,
         `HUB_OFS_IRQ_STAT, `HUB_OFS_IRQ_MASK, `HUB_OFS_ID,
         `HUB_OFS_SPEED: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic                aw_held_reg, aw_held_next;
   logic                w_held_reg, w_held_next;
   hub_pkg::axi_addr_t  aw_reg, aw_next;
   hub_pkg::axi_wdata_t w_reg, w_next;
   logic                bvalid_reg, bvalid_next;
   hub_pkg::resp_t      bresp_reg, bresp_next;
   logic                rvalid_reg, rvalid_next;
   hub_pkg::axi_rdata_t r_reg, r_next;

   logic                gang_reg, gang_next;
   hub_pkg::port_vec_t  req_reg, req_next;
   hub_pkg::port_vec_t  mask_reg, mask_next;
   hub_pkg::port_vec_t  irq_stat_reg, irq_stat_next;
   hub_pkg::port_vec_t  pwr_reg, pwr_next;
   hub_pkg::port_vec_t  ovc_prev_reg, ovc_prev_next;
   hub_pkg::port_vec_t  low_speed_reg, low_speed_next;
   logic                bus_powered_reg, bus_powered_next;
   logic                mode_seen_reg, mode_seen_next;
   logic [31:0]         id_reg, id_next;

   logic                aw_take, w_take, do_write;
   hub_pkg::axi_addr_t  wr_addr;
   hub_pkg::axi_wdata_t wr_data;
   logic [7:0]          wr_ofs;
   logic                wr_ctrl, wr_req, wr_stat, wr_mask;
   hub_pkg::port_vec_t  active_mask, ovc_now, ovc_rise, ovc_event;
   logic                mode_change;
   logic                pullup_active;
   logic [31:0]         rd_word;

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   assign S_AXI_AWREADY_O = CORE_CE_I && !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY_O  = CORE_CE_I && !w_held_reg && !bvalid_reg;
   assign S_AXI_ARREADY_O = CORE_CE_I && !rvalid_reg;
   assign aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
   assign w_take  = S_AXI_WVALID_I && S_AXI_WREADY_O;
   assign wr_addr = aw_held_reg ? aw_reg : S_AXI_AW_I;
   assign wr_data = w_held_reg ? w_reg : S_AXI_W_I;
   assign do_write = (aw_held_reg || aw_take) && (w_held_reg || w_take);
   assign wr_ofs  = {wr_addr.addr[7:2], 2'h0};
   assign wr_ctrl = do_write && wr_ofs == `HUB_OFS_CTRL;
   assign wr_req  = do_write && wr_ofs == `HUB_OFS_PWR_REQ;
   assign wr_stat = do_write && wr_ofs == `HUB_OFS_IRQ_STAT;
   assign wr_mask = do_write && wr_ofs == `HUB_OFS_IRQ_MASK;

   always_comb begin
      rd_word = 32'h0;
      case ({S_AXI_AR_I.addr[7:2], 2'h0})
         `HUB_OFS_CTRL:     rd_word[`HUB_CTRL_GANG_BIT] = gang_reg;
         `HUB_OFS_PWR_REQ:  rd_word[6:0] = req_reg;
         `HUB_OFS_STATUS: begin
            rd_word[`HUB_ST_POWER_SOURCE_SELECT_N_BIT] = bus_powered_reg;
            rd_word[`HUB_ST_PULLUP_BIT] = pullup_active;
            rd_word[`HUB_ST_MEMSEL_BIT] = SERIAL_MEMORY_SELECT_N_I;
            rd_word[`HUB_ST_POWER_LSB +: `HUB_NUM_PORTS] = pwr_reg;
            rd_word[`HUB_ST_OVC_LSB +: `HUB_NUM_PORTS] = ovc_prev_reg;
         end
         `HUB_OFS_IRQ_STAT: rd_word[6:0] = irq_stat_reg;
         `HUB_OFS_IRQ_MASK: rd_word[6:0] = mask_reg;
         `HUB_OFS_ID:       rd_word = id_reg;
         `HUB_OFS_SPEED:    rd_word[6:0] = low_speed_reg;
         default:           rd_word = 32'h0;
      endcase
   end

   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next  = w_held_reg;
      aw_next      = aw_reg;
      w_next       = w_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      r_next       = r_reg;
      if (bvalid_reg && S_AXI_BREADY_I) begin
         bvalid_next = 1'b0;
      end
      if (do_write) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = is_mapped(wr_addr.addr) ? hub_pkg::RESP_OKAY
                                                : hub_pkg::RESP_SLVERR;
      end else begin
         if (aw_take) begin
            aw_held_next = 1'b1;
            aw_next      = S_AXI_AW_I;
         end
         if (w_take) begin
            w_held_next = 1'b1;
            w_next      = S_AXI_W_I;
         end
      end
      if (rvalid_reg && S_AXI_RREADY_I) begin
         rvalid_next = 1'b0;
      end
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         rvalid_next = 1'b1;
         r_next.data = rd_word;
         r_next.resp = is_mapped(S_AXI_AR_I.addr) ? hub_pkg::RESP_OKAY
                                                  : hub_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_reg      <= '0;
         w_reg       <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= hub_pkg::RESP_OKAY;
         rvalid_reg  <= 1'b0;
         r_reg       <= '0;
      end else if (CORE_CE_I) begin
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         aw_reg      <= aw_next;
         w_reg       <= w_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         r_reg       <= r_next;
      end
   end

   assign S_AXI_BVALID_O = bvalid_reg;
   assign S_AXI_BRESP_O  = bresp_reg;
   assign S_AXI_RVALID_O = rvalid_reg;
   assign S_AXI_R_O      = r_reg;

   // ------------------------------------------------------------
   // hub power, mode, speed and id
   // ------------------------------------------------------------
   assign active_mask = bus_powered_reg ? `HUB_BUS_PORTS_MASK
                                        : `HUB_SELF_PORTS_MASK;
   assign ovc_now   = ~PORT_OVERCURRENT_SENSE_N_I & active_mask;
   assign ovc_rise  = ovc_now & ~ovc_prev_reg;
   assign ovc_event = gang_reg ? (|ovc_rise ? active_mask : '0)
                               : ovc_rise;
   assign mode_change = mode_seen_reg &&
                        (bus_powered_reg == POWER_SOURCE_SELECT_N_I);

   always_comb begin
      gang_next = wr_ctrl ? (wr_data.strb[0] ?
                  wr_data.data[`HUB_CTRL_GANG_BIT] : gang_reg) : gang_reg;
      mask_next = wr_mask ? merge_low(mask_reg, wr_data) : mask_reg;
      req_next  = wr_req ? merge_low(req_reg, wr_data) : req_reg;
      // overcurrent wins over a same-cycle request write
      if (gang_reg) begin
         if (|ovc_now) begin
            req_next = '0;
         end
      end else begin
         req_next = req_next & ~ovc_now;
      end
      if (gang_reg) begin
         pwr_next = (|(req_next & active_mask)) ?
                    active_mask : '0;
      end else begin
         pwr_next = req_next & active_mask;
      end
      irq_stat_next = irq_stat_reg;
      if (wr_stat && wr_data.strb[0]) begin
         irq_stat_next = irq_stat_reg & ~wr_data.data[6:0];
      end
      irq_stat_next    = irq_stat_next | ovc_event;
      ovc_prev_next    = ovc_now;
      bus_powered_next = !POWER_SOURCE_SELECT_N_I;
      mode_seen_next   = 1'b1;
      low_speed_next   = (low_speed_reg & ~(PORT_DATA_PLUS_I ^
                         PORT_DATA_MINUS_I)) |
                         (PORT_DATA_MINUS_I & ~PORT_DATA_PLUS_I);
      id_next = SERIAL_MEMORY_SELECT_N_I ?
                {`HUB_DEFAULT_VID, `HUB_DEFAULT_PID} : SERIAL_MEMORY_ID_I;
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         gang_reg        <= `HUB_CTRL_RST;
         req_reg         <= `HUB_PWR_REQ_RST;
         mask_reg        <= `HUB_IRQ_MASK_RST;
         irq_stat_reg    <= '0;
         pwr_reg         <= '0;
         ovc_prev_reg    <= '0;
         low_speed_reg   <= '0;
         bus_powered_reg <= 1'b0;
         mode_seen_reg   <= 1'b0;
         id_reg          <= '0;
      end else if (CORE_CE_I) begin
         gang_reg        <= gang_next;
         req_reg         <= req_next;
         mask_reg        <= mask_next;
         irq_stat_reg    <= irq_stat_next;
         pwr_reg         <= pwr_next;
         ovc_prev_reg    <= ovc_prev_next;
         low_speed_reg   <= low_speed_next;
         bus_powered_reg <= bus_powered_next;
         mode_seen_reg   <= mode_seen_next;
         id_reg          <= id_next;
      end
   end

   pullup_timer #(
      .HOLD_CYCLES (PULLUP_HOLD_CYCLES)
   ) pullup_timer_i (
      .clk_i     (CORE_CLK_I),
      .nrst_i    (NRST_I),
      .ce_i      (CORE_CE_I),
      .restart_i (mode_change),
      .active_o  (pullup_active)
   );

   assign PORT_POWER_SWITCH_ENABLE_O = pwr_reg;
   assign UPSTREAM_PULLUP_DISABLE_O  = pullup_active;
   assign PORT_LOW_SPEED_O           = low_speed_reg;
   assign REPORTED_ID_O              = id_reg;
   assign IRQ_O                      = |(irq_stat_reg & mask_reg);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!NRST_I);

   id_default_a: assert property (
      (NRST_I && CORE_CE_I && SERIAL_MEMORY_SELECT_N_I) |=>
      REPORTED_ID_O == {`HUB_DEFAULT_VID, `HUB_DEFAULT_PID})
      else $error("default ids not reported");

   indiv_follow_a: assert property (
      (CORE_CE_I && !gang_reg && !wr_req && !(|ovc_now) && !mode_change)
      |=> PORT_POWER_SWITCH_ENABLE_O == ($past(req_reg) & active_mask))
      else $error("port power does not follow request");

   indiv_ovc_a: assert property (
      (CORE_CE_I && !gang_reg && !wr_req) |=>
      ((PORT_POWER_SWITCH_ENABLE_O & $past(ovc_now)) == '0) &&
      ((req_reg & ~$past(ovc_now)) == ($past(req_reg) & ~$past(ovc_now))))
      else $error("overcurrent touched a healthy port");

   gang_on_a: assert property (
      (CORE_CE_I && gang_reg && !wr_req && !(|ovc_now) &&
       |(req_reg & active_mask)) |=>
      PORT_POWER_SWITCH_ENABLE_O == $past(active_mask))
      else $error("ganged power not on for all ports");

   gang_off_a: assert property (
      (CORE_CE_I && gang_reg && !wr_req && !(|ovc_now) &&
       !(|(req_reg & active_mask))) |=> PORT_POWER_SWITCH_ENABLE_O == '0)
      else $error("ganged power left on with no request");

   gang_ovc_a: assert property (
      (CORE_CE_I && gang_reg && |ovc_now) |=>
      PORT_POWER_SWITCH_ENABLE_O == '0 ##1 req_reg == $past(req_reg))
      else $error("ganged overcurrent left a port powered");

   mode_sample_a: assert property (
      CORE_CE_I |=> bus_powered_reg == !$past(POWER_SOURCE_SELECT_N_I))
      else $error("power mode not taken from select input");

   port_count_a: assert property (
      bus_powered_reg |=> bus_powered_reg |->
      PORT_POWER_SWITCH_ENABLE_O[6:4] == 3'h0)
      else $error("port beyond four powered in bus mode");

   mode_pulse_a: assert property (
      (CORE_CE_I && mode_change) |=> UPSTREAM_PULLUP_DISABLE_O [*3])
      else $error("pull-up disable missing after mode change");

   speed_a: assert property (
      CORE_CE_I |=>
      ((PORT_LOW_SPEED_O & $past(PORT_DATA_PLUS_I & ~PORT_DATA_MINUS_I))
       == '0) &&
      ((~PORT_LOW_SPEED_O & $past(PORT_DATA_MINUS_I & ~PORT_DATA_PLUS_I))
       == '0))
      else $error("port speed not detected");

   ovc_status_a: assert property (
      (CORE_CE_I && |ovc_rise) |=>
      (irq_stat_reg & $past(ovc_event)) == $past(ovc_event))
      else $error("overcurrent change not recorded");

   indiv_ovc_c: cover property (CORE_CE_I && !gang_reg && |ovc_rise);
   gang_ovc_c: cover property (CORE_CE_I && gang_reg && |ovc_rise);
   mode_change_c: cover property (CORE_CE_I && mode_change);
   irq_c: cover property (IRQ_O);

endmodule

// File: tb/port_partner.sv
// far-side model: downstream power switches and attached devices
module port_partner (
   input  wire logic               clk_i,
   input  wire hub_pkg::port_vec_t power_i,
   input  wire hub_pkg::port_vec_t fault_i,
   input  wire hub_pkg::port_vec_t attach_i,
   input  wire hub_pkg::port_vec_t slow_i,
   output hub_pkg::port_vec_t      ovc_n_o,
   output hub_pkg::port_vec_t      dp_o,
   output hub_pkg::port_vec_t      dm_o
);
   timeunit 1ns;
   timeprecision 1ps;
   hub_pkg::port_vec_t live;
   // flag only from a switch that is on and faulted
   always_ff @(posedge clk_i) begin
      ovc_n_o <= ~(fault_i & power_i);
   end
   // unpowered or empty ports sit at se0 through pull-downs
   assign live = attach_i & power_i;
   assign dp_o = live & ~slow_i;
   assign dm_o = live & slow_i;
endmodule

// File: tb/hub_port_power_control_tb.sv
// self-checking bench for the hub port power block
`include "hub_params.svh"
module hub_port_power_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int H = 20;
   localparam logic [31:0] MEM_ID = 32'h5a5a0f0f;
   logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0;
   logic arv = 1'b0, rre = 1'b0, msel_n = 1'b1;
   logic pwr_n = 1'b1;
   logic awr, wrdy, bv, arr, rv, irq, pud;
   hub_pkg::axi_addr_t  aw = '0, ar = '0;
   hub_pkg::axi_wdata_t w = '0;
   hub_pkg::resp_t      bresp, rs, bs;
   hub_pkg::axi_rdata_t r;
   hub_pkg::port_vec_t  fault = '0, attach = 7'h7f, slow = '0;
   hub_pkg::port_vec_t  ovc_n, dp, dm, pwr, ls;
   logic [31:0]         rid, d;
   int failures = 0, num_checks = 0, cycles = 0, n;

   always #2.5 clk = ~clk;

   hub_port_power_control #(.PULLUP_HOLD_CYCLES(H)) hub_port_power_control_i (
      .CORE_CLK_I(clk), .NRST_I(nrst), .CORE_CE_I(1'b1),
      .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AW_I(aw),
      .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_W_I(w),
      .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_BRESP_O(bresp),
      .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_AR_I(ar),
      .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .S_AXI_R_O(r),
      .IRQ_O(irq), .SERIAL_MEMORY_SELECT_N_I(msel_n),
      .SERIAL_MEMORY_ID_I(MEM_ID), .POWER_SOURCE_SELECT_N_I(pwr_n),
      .PORT_OVERCURRENT_SENSE_N_I(ovc_n), .PORT_POWER_SWITCH_ENABLE_O(pwr),
      .UPSTREAM_PULLUP_DISABLE_O(pud), .PORT_DATA_PLUS_I(dp),
      .PORT_DATA_MINUS_I(dm), .PORT_LOW_SPEED_O(ls), .REPORTED_ID_O(rid));

   port_partner port_partner_i (
      .clk_i(clk), .power_i(pwr), .fault_i(fault), .attach_i(attach),
      .slow_i(slow), .ovc_n_o(ovc_n), .dp_o(dp), .dm_o(dm));

   // ----------------------------------------------------------------
   // bus and check helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      logic ta, tw, done;
      done = 1'b0;
      @(posedge clk);
      awv <= 1;
      aw <= '{addr: a, prot: 3'h0};
      wv <= 1;
      w <= '{data: dat, strb: 4'h1};
      bre <= 1;
      while (!done) begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wrdy;
         done = bv;
         bs = bresp;
         @(posedge clk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
      end
      bre <= 0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic ta, done;
      done = 1'b0;
      @(posedge clk);
      arv <= 1;
      ar <= '{addr: a, prot: 3'h0};
      rre <= 1;
      while (!done) begin
         @(negedge clk);
         ta = arv & arr;
         done = rv;
         d = r.data;
         rs = r.resp;
         @(posedge clk);
         if (ta) arv <= 0;
      end
      rre <= 0;
   endtask

   task automatic look(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask

   // counts cycles with the pull-up disable high
   task automatic pulse();
      n = 0;
      repeat (H + 10) begin
         @(negedge clk);
         if (pud === 1'b1) n++;
      end
      chk(32'(n >= H - 1 && n <= H + 3), 32'h1);
      chk(pud, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      pulse();
      chk(rid, {`HUB_DEFAULT_VID, `HUB_DEFAULT_PID});
      rd(`HUB_OFS_ID);
      chk(d, {`HUB_DEFAULT_VID, `HUB_DEFAULT_PID});
      rd(`HUB_OFS_STATUS);
      chk(d & 32'h1, 32'h0);
   endtask

   task automatic t_id();
      @(posedge clk);
      msel_n <= 1'b0;
      look(2);
      chk(rid, MEM_ID);
      @(posedge clk);
      msel_n <= 1'b1;
      look(2);
      chk(rid, {`HUB_DEFAULT_VID, `HUB_DEFAULT_PID});
   endtask

   task automatic t_indiv();
      wr(`HUB_OFS_CTRL, 32'h0);
      chk(32'(bs), 32'(hub_pkg::RESP_OKAY));
      wr(`HUB_OFS_PWR_REQ, 32'h55);
      look(2);
      chk(pwr, 7'h55);
      wr(`HUB_OFS_PWR_REQ, 32'h54);
      look(2);
      chk(pwr, 7'h54);
      wr(`HUB_OFS_IRQ_MASK, 32'h04);
      @(posedge clk);
      fault <= 7'h04;
      look(4);
      chk(pwr, 7'h50);
      chk(irq, 32'h1);
      rd(`HUB_OFS_IRQ_STAT);
      chk(d, 32'h04);
      fault <= '0;
      wr(`HUB_OFS_IRQ_STAT, 32'h04);
      look(2);
      chk(irq, 32'h0);
   endtask

   task automatic t_gang();
      wr(`HUB_OFS_PWR_REQ, 32'h0);
      wr(`HUB_OFS_CTRL, 32'h1);
      wr(`HUB_OFS_PWR_REQ, 32'h01);
      look(2);
      chk(pwr, 7'h7f);
      wr(`HUB_OFS_PWR_REQ, 32'h02);
      look(2);
      chk(pwr, 7'h7f);
      wr(`HUB_OFS_PWR_REQ, 32'h0);
      look(2);
      chk(pwr, 7'h00);
      wr(`HUB_OFS_PWR_REQ, 32'h20);
      @(posedge clk);
      fault <= 7'h40;
      look(4);
      chk(pwr, 7'h00);
      rd(`HUB_OFS_IRQ_STAT);
      chk(d, 32'h7f);
      fault <= '0;
      wr(`HUB_OFS_IRQ_STAT, 32'h7f);
   endtask

   task automatic t_speed();
      wr(`HUB_OFS_CTRL, 32'h0);
      wr(`HUB_OFS_PWR_REQ, 32'h7f);
      slow <= 7'h08;
      look(3);
      chk(ls, 7'h08);
      rd(`HUB_OFS_SPEED);
      chk(d, 32'h08);
      slow <= '0;
      look(3);
      chk(ls, 7'h00);
   endtask

   task automatic t_unmapped();
      rd(8'h40);
      chk(32'(rs), 32'(hub_pkg::RESP_SLVERR));
      chk(d, 32'h0);
      wr(8'h40, 32'h1);
      chk(32'(bs), 32'(hub_pkg::RESP_SLVERR));
   endtask

   task automatic t_bus();
      @(posedge clk);
      pwr_n <= 1'b0;
      pulse();
      chk(pwr, 7'h0f);
      rd(`HUB_OFS_STATUS);
      chk(d & 32'h1, 32'h1);
   endtask

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic conclude();
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         conclude();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1;
      t_reset();
      t_id();
      t_indiv();
      t_gang();
      t_speed();
      t_unmapped();
      t_bus();
      conclude();
   end
endmodule
